// ===== dcs_top.sv
/*
  dcs_top: memory-to-memory stream of a source and a destination channel,
  register or descriptor driven, with a crc32 engine on the source side.
  Assumes a memory port that holds mem_ack low until the access is done
  and returns read data with mem_ack; trig_in comes from the same clock.
*/
`timescale 1ns/10ps
`include "dcs_defs.svh"
// Function
// - each stream pairs a reading source channel with a writing destination channel
// - software writes control registers; the channel starts from those values
// - at end of a circular register unit, working values reload from setup
// - descriptor mode fetches parameters from memory and chains the next sequence
// - single linear buffer halts the channel when done
// - addresses advance by a signed stride, zero allowed
// - circular mode restarts at buffer start, interrupt at each fill
// - optional interrupt at the buffer's halfway point
// - ping-pong ring of two-word descriptors: next pointer, address
// - list of four-word descriptors: next, address, length, configuration
// - array of one-word descriptors, only the base address changes
// - 2d list descriptors reload every source channel parameter; destination setup is untouched
// - channels run on the system clock with a 32-bit data bus
// - crc32 signature over the 32-bit word stream
// - scan mode feeds crc from the source, writes nothing
// - transfer mode forwards each word to the destination
// - mismatch against the expected value raises a fault event
// - generator polynomial is programmed by software
// - selectable bit and byte mirroring of data words
// - fill mode writes a constant over a 1d or 2d region
// - separate fault and error event outputs
// - trigger input can start the sequence
module dcs_top
#(
  parameter int CW = 16
)
(
  // clock and reset
  input logic clk_sys,
  input logic rst,
  // register port
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  // memory master, 32-bit
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input logic mem_ack,
  input logic [31:0] mem_rdata,
  input logic mem_err,
  // triggers and events
  input logic trig_in,
  output logic trig_out,
  output logic irq_done,
  output logic irq_frac,
  output logic crc_fault,
  output logic crc_err
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_desc(input dcs_pkg::dcs_flow_type f);
    return f == dcs_pkg::FL_RING || f == dcs_pkg::FL_LIST ||
      f == dcs_pkg::FL_ARRAY || f == dcs_pkg::FL_LIST2D;
  endfunction

  function automatic logic [2:0] d_first(input dcs_pkg::dcs_flow_type f);
    return f == dcs_pkg::FL_ARRAY ? `DCS_DW_ADDR : `DCS_DW_NEXT;
  endfunction

  function automatic logic [2:0] d_last(input dcs_pkg::dcs_flow_type f);
    case (f)
      dcs_pkg::FL_LIST: return `DCS_DW_CFG;
      dcs_pkg::FL_LIST2D: return `DCS_DW_YMOD;
      default: return `DCS_DW_ADDR;
    endcase
  endfunction

  // descriptor word to source parameter slot
  function automatic logic [3:0] d_slot(input logic [2:0] dw);
    case (dw)
      `DCS_DW_ADDR: return `DCS_P_ADDR;
      `DCS_DW_XCNT: return `DCS_P_XCNT;
      `DCS_DW_XMOD: return `DCS_P_XMOD;
      `DCS_DW_YCNT: return `DCS_P_YCNT;
      default: return `DCS_P_YMOD;
    endcase
  endfunction

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  dcs_pkg::dcs_state_type state_r;
  dcs_pkg::dcs_flow_type flow;
  dcs_pkg::dcs_mode_type mode;
  logic [31:0] ctrl_r;
  logic [31:0] par_r [`DCS_P_ALL];
  logic [31:0] dptr_r;
  logic [31:0] dnext_r;
  logic [31:0] poly_r;
  logic [31:0] seed_r;
  logic [31:0] exp_r;
  logic [31:0] fill_r;
  logic [31:0] res_r;
  logic [31:0] data_r;
  logic [31:0] ecnt_r;
  logic [31:0] total;
  logic [31:0] crc;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [2:0] dword_r;
  logic [3:0] pidx;
  logic [3:0] ld;
  logic src_last;
  logic dst_last;
  logic src_end_r;
  logic sdone_r;
  logic ddone_r;
  logic fault_r;
  logic err_r;
  logic en;
  logic need_rd;
  logic need_wr;
  logic in_par;
  logic ack_d;
  logic ack_rd;
  logic ack_wr;
  logic chk;
  logic load;
  logic zero;
  logic err_evt;
  logic stop_evt;
  logic mis;
  logic elem;
  logic d_end;
  logic st_wr;

  assign flow = dcs_pkg::dcs_flow_type'(ctrl_r[`DCS_F_FLOW]);
  assign mode = dcs_pkg::dcs_mode_type'(ctrl_r[`DCS_F_MODE]);
  assign en = ctrl_r[`DCS_B_EN];
  // scan never writes, fill never reads
  assign need_rd = mode != dcs_pkg::MD_FILL;
  assign need_wr = mode != dcs_pkg::MD_SCAN;
  assign in_par = reg_addr >= `DCS_A_SRC && reg_addr < `DCS_A_DPTR;
  assign pidx = 4'((reg_addr - `DCS_A_SRC) >> 2);
  assign ld = need_rd ? 4'h0 : `DCS_P_NUM;
  assign ack_d = state_r == dcs_pkg::ST_DESC && mem_ack;
  assign ack_rd = state_r == dcs_pkg::ST_RD && mem_ack;
  assign ack_wr = state_r == dcs_pkg::ST_WR && mem_ack;
  assign chk = state_r == dcs_pkg::ST_CHK;
  assign load = state_r == dcs_pkg::ST_LOAD;
  assign d_end = ack_d && dword_r >= d_last(flow);
  assign zero = par_r[ld + `DCS_P_XCNT] == 32'h0000_0000 || par_r[ld + `DCS_P_YCNT] == 32'h0000_0000;
  assign err_evt = (mem_req && mem_ack && mem_err) || (load && zero);
  assign stop_evt = err_evt || (chk && flow == dcs_pkg::FL_STOP);
  assign mis = ctrl_r[`DCS_B_VFY] && crc != exp_r;
  assign elem = need_rd ? ack_rd : ack_wr;
  assign total = 32'(par_r[ld + `DCS_P_XCNT] * par_r[ld + `DCS_P_YCNT]);
  assign st_wr = reg_wr && reg_addr == `DCS_A_STAT;

  // ----------------------------------------
  // channels and checksum engine
  // ----------------------------------------
  // source reads, destination writes: two channels per stream
  dcs_chan #(.CW(CW)) u_src
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(load),
    .step(ack_rd && !mem_err),
    .s_addr(par_r[`DCS_P_ADDR]),
    .s_xcnt(par_r[`DCS_P_XCNT]),
    .s_xmod(par_r[`DCS_P_XMOD]),
    .s_ycnt(par_r[`DCS_P_YCNT]),
    .s_ymod(par_r[`DCS_P_YMOD]),
    .addr(src_addr),
    .last(src_last)
  );

  dcs_chan #(.CW(CW)) u_dst
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(load),
    .step(ack_wr && !mem_err),
    .s_addr(par_r[`DCS_P_NUM + `DCS_P_ADDR]),
    .s_xcnt(par_r[`DCS_P_NUM + `DCS_P_XCNT]),
    .s_xmod(par_r[`DCS_P_NUM + `DCS_P_XMOD]),
    .s_ycnt(par_r[`DCS_P_NUM + `DCS_P_YCNT]),
    .s_ymod(par_r[`DCS_P_NUM + `DCS_P_YMOD]),
    .addr(dst_addr),
    .last(dst_last)
  );

  // fed only by source reads in scan and transfer modes
  dcs_crc u_crc
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .init(load),
    .seed(seed_r),
    .poly(poly_r),
    .bit_rev(ctrl_r[`DCS_B_BITR]),
    .byte_rev(ctrl_r[`DCS_B_BYTR]),
    .in_valid(ack_rd && !mem_err && (mode == dcs_pkg::MD_SCAN || mode == dcs_pkg::MD_XFER)),
    .in_data(mem_rdata),
    .crc(crc)
  );

  // ----------------------------------------
  // memory port
  // ----------------------------------------
  assign mem_req = state_r == dcs_pkg::ST_DESC || state_r == dcs_pkg::ST_RD || state_r == dcs_pkg::ST_WR;
  assign mem_we = state_r == dcs_pkg::ST_WR;
  // 32-bit words on clk_sys; the address mux follows flops only
  always_comb
    unique case (state_r)
      dcs_pkg::ST_DESC: mem_addr = dptr_r + {27'h0, dword_r - d_first(flow), 2'b00};
      dcs_pkg::ST_WR: mem_addr = dst_addr;
      default: mem_addr = src_addr;
    endcase
  assign mem_wdata = mode == dcs_pkg::MD_FILL ? fill_r : data_r;

  // ----------------------------------------
  // registers and descriptor loads
  // ----------------------------------------
  // software write wins over a descriptor load in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ctrl_r <= `DCS_RST_CTRL;
      for (int i = 0; i < `DCS_P_ALL; i++)
        par_r[i] <= (i == `DCS_P_YCNT || i == `DCS_P_NUM + `DCS_P_YCNT) ? `DCS_RST_YCNT : 32'h0000_0000;
      dptr_r <= 32'h0000_0000;
      poly_r <= `DCS_RST_POLY;
      seed_r <= `DCS_RST_SEED;
      exp_r <= 32'h0000_0000;
      fill_r <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr && reg_addr == `DCS_A_CTRL)
        ctrl_r <= reg_wdata;
      else if (stop_evt)
        ctrl_r[`DCS_B_EN] <= 1'b0;
      else if (ack_d && dword_r == `DCS_DW_CFG)
        ctrl_r <= {mem_rdata[31:1], 1'b1};
      if (reg_wr && in_par)
        par_r[pidx] <= reg_wdata;
      else if (ack_d && dword_r != `DCS_DW_NEXT && dword_r != `DCS_DW_CFG)
        par_r[d_slot(dword_r)] <= mem_rdata;
      if (reg_wr && reg_addr == `DCS_A_DPTR)
        dptr_r <= reg_wdata;
      else if (d_end)
        dptr_r <= flow == dcs_pkg::FL_ARRAY ? dptr_r + `DCS_WORD : dnext_r;
      if (reg_wr && reg_addr == `DCS_A_POLY)
        poly_r <= reg_wdata;
      if (reg_wr && reg_addr == `DCS_A_SEED)
        seed_r <= reg_wdata;
      if (reg_wr && reg_addr == `DCS_A_EXP)
        exp_r <= reg_wdata;
      if (reg_wr && reg_addr == `DCS_A_FILL)
        fill_r <= reg_wdata;
    end

  // descriptor word index and link pointer
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      dword_r <= 3'h0;
      dnext_r <= 32'h0000_0000;
    end
    else if (state_r != dcs_pkg::ST_DESC)
      dword_r <= d_first(flow);
    else if (ack_d)
    begin
      dword_r <= dword_r + 3'h1;
      if (dword_r == `DCS_DW_NEXT)
        dnext_r <= mem_rdata;
    end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // the arm state costs a cycle but decouples start from the write
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      state_r <= dcs_pkg::ST_IDLE;
    else if (err_evt)
      state_r <= dcs_pkg::ST_IDLE;
    else
      unique case (state_r)
        dcs_pkg::ST_IDLE:
          if (reg_wr && reg_addr == `DCS_A_CTRL && reg_wdata[`DCS_B_EN])
            state_r <= dcs_pkg::ST_ARM;
        dcs_pkg::ST_ARM:
          if (!en)
            state_r <= dcs_pkg::ST_IDLE;
          else if (!ctrl_r[`DCS_B_TRIG] || trig_in)
            state_r <= is_desc(flow) ? dcs_pkg::ST_DESC : dcs_pkg::ST_LOAD;
        dcs_pkg::ST_DESC:
          if (d_end)
            state_r <= dcs_pkg::ST_LOAD;
        dcs_pkg::ST_LOAD:
          state_r <= need_rd ? dcs_pkg::ST_RD : dcs_pkg::ST_WR;
        dcs_pkg::ST_RD:
          if (mem_ack)
            state_r <= need_wr ? dcs_pkg::ST_WR : src_last ? dcs_pkg::ST_CHK : dcs_pkg::ST_RD;
        dcs_pkg::ST_WR:
          if (mem_ack && (need_rd ? src_end_r : dst_last))
            state_r <= dcs_pkg::ST_CHK;
          else if (mem_ack)
            state_r <= need_rd ? dcs_pkg::ST_RD : dcs_pkg::ST_WR;
        dcs_pkg::ST_CHK:
          if (!en || flow == dcs_pkg::FL_STOP)
            state_r <= dcs_pkg::ST_IDLE;
          else if (flow == dcs_pkg::FL_CIRC)
            state_r <= dcs_pkg::ST_LOAD;
          else
            state_r <= dcs_pkg::ST_DESC;
        default:
          state_r <= dcs_pkg::ST_IDLE;
      endcase

  // ----------------------------------------
  // data path
  // ----------------------------------------
  // read word held for the destination write
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      data_r <= 32'h0000_0000;
      src_end_r <= 1'b0;
      ecnt_r <= 32'h0000_0000;
    end
    else if (load)
    begin
      src_end_r <= 1'b0;
      ecnt_r <= 32'h0000_0000;
    end
    else
    begin
      if (ack_rd)
      begin
        data_r <= mem_rdata;
        src_end_r <= src_last;
      end
      if (elem)
        ecnt_r <= ecnt_r + 32'h0000_0001;
    end

  // ----------------------------------------
  // events and status
  // ----------------------------------------
  // one-cycle event pulses, all from flops
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      irq_done <= 1'b0;
      trig_out <= 1'b0;
      irq_frac <= 1'b0;
      crc_fault <= 1'b0;
      crc_err <= 1'b0;
    end
    else
    begin
      irq_done <= chk;
      trig_out <= chk;
      irq_frac <= ctrl_r[`DCS_B_HALF] && elem && ecnt_r + 32'h0000_0001 == total >> 1;
      crc_fault <= chk && mis;
      crc_err <= err_evt;
    end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      sdone_r <= 1'b0;
      ddone_r <= 1'b0;
      fault_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      sdone_r <= (chk && need_rd) || (sdone_r && !(st_wr && reg_wdata[`DCS_S_SDONE]));
      ddone_r <= (chk && need_wr) || (ddone_r && !(st_wr && reg_wdata[`DCS_S_DDONE]));
      fault_r <= (chk && mis) || (fault_r && !(st_wr && reg_wdata[`DCS_S_FAULT]));
      err_r <= err_evt || (err_r && !(st_wr && reg_wdata[`DCS_S_ERR]));
    end

  // signature latched at end of pass
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      res_r <= 32'h0000_0000;
    else if (chk)
      res_r <= crc;

  // read data stand one cycle; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else if (in_par)
      reg_rdata <= par_r[pidx];
    else
      unique case (reg_addr)
        `DCS_A_CTRL: reg_rdata <= ctrl_r;
        `DCS_A_STAT: reg_rdata <= {27'h0, err_r, fault_r, ddone_r, sdone_r, state_r != dcs_pkg::ST_IDLE};
        `DCS_A_DPTR: reg_rdata <= dptr_r;
        `DCS_A_POLY: reg_rdata <= poly_r;
        `DCS_A_SEED: reg_rdata <= seed_r;
        `DCS_A_EXP: reg_rdata <= exp_r;
        `DCS_A_RES: reg_rdata <= res_r;
        `DCS_A_FILL: reg_rdata <= fill_r;
        `DCS_A_CUR: reg_rdata <= src_addr;
        default: reg_rdata <= 32'h0000_0000;
      endcase

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // a zero count is a legal abort at load, not a stall
  sequence s_load_run;
    load ##1 (state_r == dcs_pkg::ST_RD || state_r == dcs_pkg::ST_WR || $past(zero));
  endsequence

  property p_chain;
    d_end && !mem_err |=> s_load_run;
  endproperty
  a_chain: assert property (p_chain) else $error("no start after descriptor");

  property p_start;
    state_r == dcs_pkg::ST_IDLE && reg_wr && reg_addr == `DCS_A_CTRL && reg_wdata[`DCS_B_EN]
      |=> state_r == dcs_pkg::ST_ARM;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_circ;
    chk && en && flow == dcs_pkg::FL_CIRC |=> s_load_run;
  endproperty
  a_circ: assert property (p_circ) else $error("circular did not restart");

  property p_stop;
    chk && flow == dcs_pkg::FL_STOP |=> state_r == dcs_pkg::ST_IDLE && !en;
  endproperty
  a_stop: assert property (p_stop) else $error("linear did not halt");

  property p_fault;
    chk && mis |=> crc_fault ##1 !crc_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("mismatch not flagged");

  property p_scan;
    mem_we |-> mode != dcs_pkg::MD_SCAN;
  endproperty
  a_scan: assert property (p_scan) else $error("scan wrote memory");

  property p_res;
    !chk |=> $stable(res_r);
  endproperty
  a_res: assert property (p_res) else $error("result moved");

  property p_sticky;
    sdone_r && !st_wr |=> sdone_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");

  property p_trig;
    state_r == dcs_pkg::ST_ARM && en && trig_in |=> state_r inside {dcs_pkg::ST_DESC, dcs_pkg::ST_LOAD};
  endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
endmodule

// ===== dcs_defs.svh
/*
  dcs_defs.svh: register offsets, field positions, reset values and
  descriptor word indices of the dma channel pair with crc scan.
  Assumes byte addresses on an 8-bit register port, one word per register.
*/
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCS_A_CTRL 8'h00
`define DCS_A_STAT 8'h04
`define DCS_A_SRC 8'h08
`define DCS_A_DPTR 8'h30
`define DCS_A_POLY 8'h34
`define DCS_A_SEED 8'h38
`define DCS_A_EXP 8'h3c
`define DCS_A_RES 8'h40
`define DCS_A_FILL 8'h44
`define DCS_A_CUR 8'h48
// ----------------------------------------
// control and status fields
// ----------------------------------------
`define DCS_B_EN 0
`define DCS_F_FLOW 3:1
`define DCS_F_MODE 5:4
`define DCS_B_VFY 6
`define DCS_B_BITR 7
`define DCS_B_BYTR 8
`define DCS_B_HALF 9
`define DCS_B_TRIG 10
`define DCS_S_BUSY 0
`define DCS_S_SDONE 1
`define DCS_S_DDONE 2
`define DCS_S_FAULT 3
`define DCS_S_ERR 4
// ----------------------------------------
// parameter slots, descriptor words, resets
// ----------------------------------------
`define DCS_P_ADDR 4'h0
`define DCS_P_XCNT 4'h1
`define DCS_P_XMOD 4'h2
`define DCS_P_YCNT 4'h3
`define DCS_P_YMOD 4'h4
`define DCS_P_NUM 4'h5
`define DCS_P_ALL 10
`define DCS_DW_NEXT 3'h0
`define DCS_DW_ADDR 3'h1
`define DCS_DW_XCNT 3'h2
`define DCS_DW_CFG 3'h3
`define DCS_DW_XMOD 3'h4
`define DCS_DW_YCNT 3'h5
`define DCS_DW_YMOD 3'h6
`define DCS_WORD 32'h0000_0004
`define DCS_RST_CTRL 32'h0000_0000
`define DCS_RST_YCNT 32'h0000_0001
`define DCS_RST_POLY 32'h04c1_1db7
`define DCS_RST_SEED 32'hffff_ffff
`endif

// ===== dcs_pkg.sv
/*
  dcs_pkg: state, flow and checksum mode types of the channel pair.
  Assumes nothing of its surroundings.
*/
package dcs_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_ARM = 3'h1, ST_DESC = 3'h2,
    ST_LOAD = 3'h3, ST_RD = 3'h4, ST_WR = 3'h5, ST_CHK = 3'h6} dcs_state_type;
  typedef enum logic [2:0] {FL_STOP = 3'h0, FL_CIRC = 3'h1, FL_RING = 3'h2,
    FL_LIST = 3'h3, FL_ARRAY = 3'h4, FL_LIST2D = 3'h5} dcs_flow_type;
  typedef enum logic [1:0] {MD_COPY = 2'h0, MD_SCAN = 2'h1, MD_XFER = 2'h2,
    MD_FILL = 2'h3} dcs_mode_type;
endpackage

// ===== dcs_crc.sv
/*
  dcs_crc: crc32 engine, one 32-bit word per cycle, programmable
  polynomial and optional bit and byte mirroring of the input word.
  Assumes init and in_valid never come in the same cycle.
*/
`timescale 1ns/10ps
module dcs_crc
(
  // clock and reset
  input logic clk_sys,
  input logic rst,
  // control
  input logic init,
  input logic [31:0] seed,
  input logic [31:0] poly,
  input logic bit_rev,
  input logic byte_rev,
  // data
  input logic in_valid,
  input logic [31:0] in_data,
  output logic [31:0] crc
);
  // msb-first serial division, unrolled into one cycle
  function automatic logic [31:0] crc_word(input logic [31:0] c,
    input logic [31:0] d, input logic [31:0] p);
    logic fb;
    for (int i = 31; i >= 0; i--)
    begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000);
    end
    return c;
  endfunction

  logic [31:0] w;
  // mirroring lets either endianness give the same signature
  always_comb
  begin
    w = byte_rev ? {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]} : in_data;
    if (bit_rev)
      w = {<<{w}};
  end

  // running signature; held between passes
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      crc <= 32'h0000_0000;
    else if (init)
      crc <= seed;
    else if (in_valid)
      crc <= crc_word(crc, w, poly);

  property p_crc_seed;
    @(posedge clk_sys) disable iff (rst) init |=> crc == $past(seed) ##1 ($past(in_valid) || crc == $past(seed, 2));
  endproperty
  a_crc_seed: assert property (p_crc_seed) else $error("crc not seeded");
endmodule

// ===== dcs_chan.sv
/*
  dcs_chan: address generator of one channel, linear or 2d with signed
  strides, reloaded from the setup values at the start of each unit.
  Assumes step only while the unit has elements left.
*/
`timescale 1ns/10ps
module dcs_chan
#(
  parameter int CW = 16
)
(
  // clock and reset
  input logic clk_sys,
  input logic rst,
  // control
  input logic load,
  input logic step,
  // setup values
  input logic [31:0] s_addr,
  input logic [31:0] s_xcnt,
  input logic [31:0] s_xmod,
  input logic [31:0] s_ycnt,
  input logic [31:0] s_ymod,
  // position
  output logic [31:0] addr,
  output logic last
);
  logic [CW-1:0] x_r;
  logic [CW-1:0] y_r;

  // counters of one row and of rows
  assign last = x_r <= CW'(1) && y_r <= CW'(1);

  // reload restores the setup values; strides wrap, so negative works
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      addr <= 32'h0000_0000;
      x_r <= '0;
      y_r <= '0;
    end
    else if (load)
    begin
      addr <= s_addr;
      x_r <= s_xcnt[CW-1:0];
      y_r <= s_ycnt[CW-1:0];
    end
    else if (step && x_r > CW'(1))
    begin
      addr <= addr + s_xmod;
      x_r <= x_r - CW'(1);
    end
    else if (step && y_r > CW'(1))
    begin
      addr <= addr + s_ymod;
      x_r <= s_xcnt[CW-1:0];
      y_r <= y_r - CW'(1);
    end

  property p_stride;
    @(posedge clk_sys) disable iff (rst)
      step && !load && x_r > CW'(1) |=> addr == $past(addr) + $past(s_xmod);
  endproperty
  a_stride: assert property (p_stride) else $error("stride not applied");
endmodule

// ===== dcs_mem.sv
/*
  dcs_mem: word memory on the far side of the dma memory port.
  Assumes one access at a time, held by the requester until acked.
*/
`timescale 1ns/10ps
module dcs_mem
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pacing
  input wire logic slow,
  // access
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic err,
  output logic [31:0] rdata
);
  logic [31:0] m [0:255];
  logic w;
  logic go;
  // slow mode acks every other cycle; the upper half of the space answers with an error
  assign go = req && !ack && (!slow || w);
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
      err <= 1'b0;
      w <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      w <= ~w;
      ack <= go;
      err <= go && addr[31];
      // outside an ack the read bus churns so stale data never looks valid
      rdata <= (go && !we) ? m[addr[9:2]] : ~rdata;
      if (go && we && !addr[31])
        m[addr[9:2]] <= wdata;
    end
  end
endmodule

// ===== dma_channels_with_crc_scan_bench.sv
/*
  dma_channels_with_crc_scan_bench: random and corner runs of the channel pair.
  Assumes the register map and descriptor layout of the channel pair header.
*/
`timescale 1ns/10ps
`include "dcs_defs.svh"
module dma_channels_with_crc_scan_bench;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, trig_in = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, mem_addr, mem_wdata, mem_rdata, poly, crc;
  logic mem_req, mem_we, mem_ack, mem_err, trig_out, irq_done, irq_frac, crc_fault, crc_err;
  int mismatches = 0, compares = 0, seed = 32'h0c46, n = 1, nd = 0, nf = 0, nq = 0, ne = 0, nt = 0;
  logic [31:0] src [0:7];
  always #10 clk_sys = ~clk_sys;
  dcs_top #(.CW(16)) dcs_top_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_err(mem_err), .trig_in(trig_in), .trig_out(trig_out), .irq_done(irq_done),
    .irq_frac(irq_frac), .crc_fault(crc_fault), .crc_err(crc_err));
  dcs_mem dcs_mem_i (.clk_sys(clk_sys), .rst(rst), .slow(slow), .req(mem_req), .we(mem_we), .addr(mem_addr),
    .wdata(mem_wdata), .ack(mem_ack), .err(mem_err), .rdata(mem_rdata));
  // event pulses counted as they stand
  always @(posedge clk_sys)
  begin
    nd <= nd + (irq_done === 1'b1);
    nf <= nf + (irq_frac === 1'b1);
    nq <= nq + (crc_fault === 1'b1);
    ne <= ne + (crc_err === 1'b1);
    nt <= nt + (trig_out === 1'b1);
  end
  // msb-first crc of one word, no final inversion
  function automatic logic [31:0] crc_f(input logic [31:0] c, input logic [31:0] d);
    c = c ^ d;
    for (int i = 0; i < 32; i++)
      c = c[31] ? ({c[30:0], 1'b0} ^ poly) : {c[30:0], 1'b0};
    return c;
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // bounded wait for a number of finished or aborted units
  task automatic wt(input int units);
    int d0;
    d0 = nd + ne + units;
    for (int i = 0; i < 900 && nd + ne < d0; i++)
      @(posedge clk_sys);
    if (nd + ne < d0)
    begin
      mismatches++;
      summarize();
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic run(input logic [31:0] c, input int units);
    wr(`DCS_A_CTRL, c);
    wt(units);
  endtask
  // fresh random source words, running crc of them
  task automatic load();
    crc = `DCS_RST_SEED;
    for (int i = 0; i < 8; i++)
    begin
      src[i] = $random(seed);
      dcs_mem_i.m[i] = src[i];
      dcs_mem_i.m[8 + i] = ~src[i];
      dcs_mem_i.m[64 + i] = 32'h0000_0000;
      if (i < n)
        crc = crc_f(crc, src[i]);
    end
  endtask
  // destination is written backwards by a negative stride
  task automatic chkdst(input logic [31:0] x);
    for (int i = 0; i < n; i++)
      chk(dcs_mem_i.m[64 + n - 1 - i], src[i] ^ x);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`DCS_A_CTRL, `DCS_RST_CTRL);
    rd(`DCS_A_POLY, `DCS_RST_POLY);
    rd(8'hfc, 32'h0000_0000);
    n = 1 + ($random(seed) & 7);
    poly = $random(seed) | 32'h0000_0001;
    wr(`DCS_A_POLY, poly);
    wr(8'h0c, n);
    wr(8'h10, `DCS_WORD);
    wr(8'h1c, 32'h0000_0100 + 4 * (n - 1));
    wr(8'h20, n);
    wr(8'h24, 32'hffff_fffc);
    // same setup replayed, fast then slow memory
    for (int p = 0; p < 2; p++)
    begin
      slow <= p[0];
      load();
      run(32'h0000_0001, 1);
      chkdst(32'h0000_0000);
      rd(`DCS_A_STAT, 32'h0000_0006);
      wr(`DCS_A_STAT, 32'h0000_0006);
      rd(`DCS_A_STAT, 32'h0000_0000);
    end
    load();
    wr(`DCS_A_EXP, crc);
    run(32'h0000_0051, 1);
    rd(`DCS_A_RES, crc);
    chk(dcs_mem_i.m[64], 32'h0000_0000);
    chk(nq, 0);
    wr(`DCS_A_EXP, ~crc);
    run(32'h0000_0051, 1);
    chk(nq, 1);
    load();
    run(32'h0000_0021, 1);
    chkdst(32'h0000_0000);
    rd(`DCS_A_RES, crc);
    wr(`DCS_A_FILL, 32'h5a5a_00ff);
    run(32'h0000_0031, 1);
    for (int i = 0; i < n; i++)
      chk(dcs_mem_i.m[64 + i], 32'h5a5a_00ff);
    // two chained four-word descriptors, the second stops
    load();
    dcs_mem_i.m[128] = 32'h0000_0210;
    dcs_mem_i.m[129] = 32'h0000_0000;
    dcs_mem_i.m[130] = n;
    dcs_mem_i.m[131] = 32'h0000_0007;
    dcs_mem_i.m[132] = 32'h0000_0000;
    dcs_mem_i.m[133] = 32'h0000_0020;
    dcs_mem_i.m[134] = n;
    dcs_mem_i.m[135] = 32'h0000_0001;
    wr(`DCS_A_DPTR, 32'h0000_0200);
    run(32'h0000_0007, 2);
    chkdst(32'hffff_ffff);
    wr(`DCS_A_SRC, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0004);
    wr(8'h20, 32'h0000_0004);
    n = nf;
    run(32'h0000_0203, 2);
    chk(nf - n >= 2, 1);
    wr(`DCS_A_CTRL, 32'h0000_0000);
    repeat (40) @(posedge clk_sys);
    n = nd;
    wr(`DCS_A_CTRL, 32'h0000_0401);
    repeat (20) @(posedge clk_sys);
    chk(nd, n);
    trig_in <= 1'b1;
    @(posedge clk_sys);
    trig_in <= 1'b0;
    wt(1);
    chk(nd, n + 1);
    n = ne;
    wr(`DCS_A_SRC, 32'h8000_0000);
    run(32'h0000_0001, 1);
    chk(ne, n + 1);
    chk(nt, nd);
    summarize();
  end
endmodule
